// *** cfg_lp_pkg.sv ***
// types shared by the option and low-power control block
`include "cfg_lp_regs.svh"
package cfg_lp_pkg;

    typedef enum logic [4:0] {
        ST_POR   = 5'b00001,
        ST_RUN   = 5'b00010,
        ST_WAIT  = 5'b00100,
        ST_STOP  = 5'b01000,
        ST_RECOV = 5'b10000
    } state_e;

    typedef struct packed {
        state_e              st;
        logic [7:0]          cfg;
        logic [`CNT_W-1:0]   cnt;
        logic                rst_pls;
        logic                iset;
        logic                iclr;
        logic [3:0]          cause;
        logic [31:0]         rdata;
    } ctl_s;

    typedef struct packed {
        logic [`WDOG_W-1:0]  cnt;
        logic                ovf;
    } wdog_s;

endpackage

// *** cfg_lp_regs.svh ***
// register offsets, field positions, reset values and delay counts
`ifndef CFG_LP_REGS_SVH
`define CFG_LP_REGS_SVH

`define CFG_OFF        12'h000
`define WDCLR_OFF      12'h004
`define STAT_OFF       12'h008

`define BIT_WDOG_DIS   0
`define BIT_STOP_EN    1
`define BIT_SHORT_STOP_RECOVERY      2
`define BIT_TRIP       3
`define BIT_PWR_DIS    4
`define BIT_RST_DIS    5

`define CFG_RESET      8'h00
`define CFG_KEEP_MASK  8'h08

`define CAUSE_LOWV     0
`define CAUSE_WDOG     1
`define CAUSE_ILLEGAL  2
`define CAUSE_PIN      3

`define SHORT_REC_CYC  32
`define LONG_REC_CYC   4096
`define POR_STAB_CYC   4096
`define CNT_W          13
`define WDOG_W         18

`endif

// *** config_low_power_control.sv ***
// system option register, stop and wait sequencing, reset routing
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "cfg_lp_regs.svh"

module config_low_power_control #(
    parameter int SHORT_RECOVERY = `SHORT_REC_CYC,
    parameter int LONG_RECOVERY  = `LONG_REC_CYC,
    parameter int POR_STABILIZE  = `POR_STAB_CYC
) (
    input  wire logic        CLK,
    input  wire logic        RESET_N,
    input  wire logic        CE,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic [31:0]      PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    input  wire logic        WAIT_REQ,
    input  wire logic        STOP_REQ,
    input  wire logic        INT_REQ,
    input  wire logic        EXT_INT,
    input  wire logic        LOWV_TRIP,
    input  wire logic        RESET_REQ,
    output logic             CPU_CLK_EN,
    output logic             SYS_RESET,
    output logic             IMASK_SET,
    output logic             IMASK_CLEAR,
    output logic             LOWV_POWER_EN,
    output logic             LOWV_RANGE_5V,
    output logic             WATCHDOG_ACTIVE
);

    localparam logic [`CNT_W-1:0] SHORT_LOAD =
        `CNT_W'(SHORT_RECOVERY - 1);
    localparam logic [`CNT_W-1:0] LONG_LOAD =
        `CNT_W'(LONG_RECOVERY - 1);
    localparam logic [`CNT_W-1:0] POR_LOAD =
        `CNT_W'(POR_STABILIZE - 1);

    cfg_lp_pkg::ctl_s r_reg;
    cfg_lp_pkg::ctl_s r_next;

    logic              wd_ovf;
    logic              wd_run;
    logic              wd_clear;
    logic              lowv_rst;
    logic              illegal;
    logic              any_rst;
    logic              addr_ok;
    logic              wr_en;
    logic              stop_enter;
    logic [`CNT_W-1:0] rec_load;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    assign addr_ok = (PADDR == `CFG_OFF) || (PADDR == `WDCLR_OFF) ||
                     (PADDR == `STAT_OFF);
    assign PREADY  = CE;
    assign PSLVERR = PSEL && PENABLE && !addr_ok;
    assign PRDATA  = r_reg.rdata;
    assign wr_en   = PSEL && PENABLE && PWRITE && CE && addr_ok;

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    assign lowv_rst = LOWV_TRIP &&
                      !r_reg.cfg[`BIT_PWR_DIS] &&
                      !r_reg.cfg[`BIT_RST_DIS];
    assign illegal  = STOP_REQ && (r_reg.st == cfg_lp_pkg::ST_RUN) &&
                      !WAIT_REQ &&
                      !r_reg.cfg[`BIT_STOP_EN];
    assign any_rst  = (lowv_rst || wd_ovf || illegal || RESET_REQ) &&
                      (r_reg.st != cfg_lp_pkg::ST_POR);
    assign stop_enter = STOP_REQ && !WAIT_REQ &&
                        (r_reg.st == cfg_lp_pkg::ST_RUN) &&
                        r_reg.cfg[`BIT_STOP_EN];
    assign rec_load = r_reg.cfg[`BIT_SHORT_STOP_RECOVERY] ? SHORT_LOAD
                                            : LONG_LOAD;

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    assign wd_run = !r_reg.cfg[`BIT_WDOG_DIS] &&
                    (r_reg.st != cfg_lp_pkg::ST_POR) &&
                    (r_reg.st != cfg_lp_pkg::ST_STOP);
    assign wd_clear = (wr_en && (PADDR == `WDCLR_OFF)) ||
                      stop_enter || r_reg.rst_pls;

    watchdog_counter u_wdog (
        .CLK      (CLK),
        .RESET_N  (RESET_N),
        .CE       (CE),
        .RUN_EN   (wd_run),
        .CLEAR    (wd_clear),
        .OVERFLOW (wd_ovf)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        r_next         = r_reg;
        r_next.rst_pls = 1'b0;
        r_next.iset    = 1'b0;
        r_next.iclr    = 1'b0;

        if (PSEL && !PENABLE) begin
            case (PADDR)
                `CFG_OFF: begin
                    r_next.rdata = {24'h000000, r_reg.cfg};
                end
                `STAT_OFF: begin
                    r_next.rdata = {23'h000000, r_reg.cause, r_reg.st};
                end
                default: begin
                    r_next.rdata = 32'h00000000;
                end
            endcase
        end

        if (wr_en && (PADDR == `CFG_OFF)) begin
            r_next.cfg = PWDATA[7:0];
        end

        case (r_reg.st)
            cfg_lp_pkg::ST_POR: begin
                if (r_reg.cnt == '0) begin
                    r_next.st = cfg_lp_pkg::ST_RUN;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            cfg_lp_pkg::ST_RUN: begin
                if (WAIT_REQ) begin
                    r_next.st   = cfg_lp_pkg::ST_WAIT;
                    r_next.iclr = 1'b1;
                end else if (stop_enter) begin
                    r_next.st   = cfg_lp_pkg::ST_STOP;
                    r_next.iclr = 1'b1;
                end
            end
            cfg_lp_pkg::ST_WAIT: begin
                if (INT_REQ) begin
                    r_next.st = cfg_lp_pkg::ST_RUN;
                end
            end
            cfg_lp_pkg::ST_STOP: begin
                if (EXT_INT) begin
                    r_next.st  = cfg_lp_pkg::ST_RECOV;
                    r_next.cnt = rec_load;
                end
            end
            cfg_lp_pkg::ST_RECOV: begin
                if (r_reg.cnt == '0) begin
                    r_next.st = cfg_lp_pkg::ST_RUN;
                end else begin
                    r_next.cnt = r_reg.cnt - 1'b1;
                end
            end
            default: begin
                r_next.st = cfg_lp_pkg::ST_RUN;
            end
        endcase

        if (any_rst) begin
            r_next.rst_pls = 1'b1;
            r_next.iset    = 1'b1;
            r_next.iclr    = 1'b0;
            r_next.cause[`CAUSE_LOWV]    = lowv_rst;
            r_next.cause[`CAUSE_WDOG]    = wd_ovf;
            r_next.cause[`CAUSE_ILLEGAL] = illegal;
            r_next.cause[`CAUSE_PIN]     = RESET_REQ;
            r_next.cfg = (r_reg.cfg & `CFG_KEEP_MASK) |
                         (`CFG_RESET & ~`CFG_KEEP_MASK);
            if ((r_reg.st == cfg_lp_pkg::ST_STOP) ||
                (r_reg.st == cfg_lp_pkg::ST_RECOV)) begin
                r_next.st  = cfg_lp_pkg::ST_RECOV;
                r_next.cnt = lowv_rst ? LONG_LOAD : rec_load;
            end else begin
                r_next.st = cfg_lp_pkg::ST_RUN;
            end
        end
    end

    // ------------------------------------------------------------
    // state register
    // ------------------------------------------------------------
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_reg.st      <= cfg_lp_pkg::ST_POR;
            r_reg.cfg     <= `CFG_RESET;
            r_reg.cnt     <= POR_LOAD;
            r_reg.rst_pls <= 1'b0;
            r_reg.iset    <= 1'b0;
            r_reg.iclr    <= 1'b0;
            r_reg.cause   <= 4'h0;
            r_reg.rdata   <= 32'h00000000;
        end else if (CE) begin
            r_reg <= r_next;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign CPU_CLK_EN      = (r_reg.st == cfg_lp_pkg::ST_RUN);
    assign SYS_RESET       = r_reg.rst_pls;
    assign IMASK_SET       = r_reg.iset;
    assign IMASK_CLEAR     = r_reg.iclr;
    assign LOWV_POWER_EN   = !r_reg.cfg[`BIT_PWR_DIS];
    assign LOWV_RANGE_5V   = r_reg.cfg[`BIT_TRIP];
    assign WATCHDOG_ACTIVE = wd_run;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);

    a_lowv_reset_pass: assert property (
        (CE && lowv_rst && r_reg.st != cfg_lp_pkg::ST_POR)
        |=> (SYS_RESET && r_reg.cause[`CAUSE_LOWV]))
        else $error("low-voltage reset not passed on");

    a_lowv_power_off: assert property (
        (CE && LOWV_TRIP && r_reg.cfg[`BIT_PWR_DIS] && !wd_ovf &&
         !RESET_REQ && !illegal)
        |=> !SYS_RESET)
        else $error("reset from powered-off monitor");

    a_trip_kept: assert property (
        SYS_RESET |-> $stable(LOWV_RANGE_5V))
        else $error("trip range changed by system reset");

    a_stop_delay_load: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_STOP && EXT_INT && !any_rst)
        |=> (r_reg.st == cfg_lp_pkg::ST_RECOV &&
             r_reg.cnt == $past(rec_load)))
        else $error("wrong stop recovery delay");

    a_lowv_long_rec: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_STOP && lowv_rst)
        |=> (r_reg.st == cfg_lp_pkg::ST_RECOV && r_reg.cnt == LONG_LOAD))
        else $error("low-voltage stop exit not long");

    a_por_hold: assert property (
        (r_reg.st == cfg_lp_pkg::ST_POR && r_reg.cnt != '0)
        |=> (r_reg.st == cfg_lp_pkg::ST_POR && !CPU_CLK_EN))
        else $error("power-on delay cut short");

    a_illegal_stop: assert property (
        (CE && illegal)
        |=> (SYS_RESET && r_reg.cause[`CAUSE_ILLEGAL] &&
             r_reg.st == cfg_lp_pkg::ST_RUN))
        else $error("illegal stop not reset");

    a_wdog_disabled: assert property (
        (CE && r_reg.cfg[`BIT_WDOG_DIS]) |-> (!WATCHDOG_ACTIVE ##1 !wd_ovf))
        else $error("watchdog active while disabled");

    a_wdog_reset: assert property (
        (CE && wd_ovf && r_reg.st != cfg_lp_pkg::ST_POR)
        |=> (SYS_RESET && IMASK_SET))
        else $error("watchdog overflow without reset");

    a_wait_entry: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_RUN && WAIT_REQ && !any_rst)
        |=> (IMASK_CLEAR && !CPU_CLK_EN))
        else $error("wait entry wrong");

    a_wait_int_exit: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_WAIT && INT_REQ && !any_rst)
        |=> (CPU_CLK_EN && !IMASK_SET))
        else $error("wait exit by interrupt wrong");

    a_stop_entry: assert property (
        (CE && stop_enter && !any_rst)
        |=> (IMASK_CLEAR && r_reg.st == cfg_lp_pkg::ST_STOP))
        else $error("stop entry wrong");

    a_recov_gated: assert property (
        (r_reg.st == cfg_lp_pkg::ST_RECOV && r_reg.cnt != '0 && !any_rst)
        |=> !CPU_CLK_EN)
        else $error("clock restarted early");

    a_recov_release: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_RECOV && r_reg.cnt == '0 &&
         !any_rst)
        |=> CPU_CLK_EN)
        else $error("clock not restarted after delay");

    a_por_release: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_POR && r_reg.cnt == '0)
        |=> CPU_CLK_EN)
        else $error("power-on delay overrun");

    a_reset_sets_mask: assert property (
        SYS_RESET |-> (IMASK_SET && !IMASK_CLEAR))
        else $error("reset without mask set");

    a_wait_reset_exit: assert property (
        (CE && r_reg.st == cfg_lp_pkg::ST_WAIT && any_rst)
        |=> (SYS_RESET && IMASK_SET && CPU_CLK_EN))
        else $error("wait exit by reset wrong");

    a_stop_refused: assert property (
        (CE && STOP_REQ && !WAIT_REQ && r_reg.st == cfg_lp_pkg::ST_RUN &&
         !r_reg.cfg[`BIT_STOP_EN])
        |=> (r_reg.st == cfg_lp_pkg::ST_RUN && !IMASK_CLEAR))
        else $error("disabled stop was executed");

    a_lowv_reset_off: assert property (
        (CE && LOWV_TRIP && r_reg.cfg[`BIT_RST_DIS] && !wd_ovf &&
         !RESET_REQ && !illegal)
        |=> !SYS_RESET)
        else $error("disabled low-voltage reset passed");

    c_wait_cycle: cover property (
        r_reg.st == cfg_lp_pkg::ST_WAIT ##1 CPU_CLK_EN);
    c_stop_recover: cover property (
        r_reg.st == cfg_lp_pkg::ST_RECOV ##1 r_reg.st == cfg_lp_pkg::ST_RUN);
    c_wdog_reset: cover property (
        SYS_RESET && r_reg.cause[`CAUSE_WDOG]);
    c_illegal_stop: cover property (
        SYS_RESET && r_reg.cause[`CAUSE_ILLEGAL]);

endmodule // config_low_power_control

// *** tb_top.sv ***
// self-checking bench for the option and low-power control block
`timescale 1ns/1ps
`include "cfg_lp_regs.svh"
module tb_top;
// ----------------------------------------------------------------
// signals and design instance
// ----------------------------------------------------------------
localparam int SHORT_N = 4;
localparam int LONG_N  = 16;
localparam int POR_N   = 16;
typedef struct {
    logic [7:0] cfg;
    logic       pwr;
    logic       rng;
    logic       wd;
} row_t;
logic        clk, reset_n, ce, psel, penable, pwrite;
logic [11:0] paddr;
logic [31:0] pwdata, prdata;
logic        pready, pslverr, wait_req, stop_req, int_req, ext_int;
logic        lowv_trip, reset_req, cpu_clk_en, sys_reset, imask_set;
logic        imask_clear, lowv_power_en, lowv_range_5v, watchdog_active;
int          failures, checked, cycles, n;
logic [31:0] rd;
logic        err;
row_t        rows [5];
config_low_power_control #(
    .SHORT_RECOVERY(SHORT_N), .LONG_RECOVERY(LONG_N),
    .POR_STABILIZE(POR_N)
) dut_u (
    .CLK(clk), .RESET_N(reset_n), .CE(ce), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .WAIT_REQ(wait_req), .STOP_REQ(stop_req),
    .INT_REQ(int_req), .EXT_INT(ext_int), .LOWV_TRIP(lowv_trip),
    .RESET_REQ(reset_req), .CPU_CLK_EN(cpu_clk_en),
    .SYS_RESET(sys_reset), .IMASK_SET(imask_set),
    .IMASK_CLEAR(imask_clear), .LOWV_POWER_EN(lowv_power_en),
    .LOWV_RANGE_5V(lowv_range_5v), .WATCHDOG_ACTIVE(watchdog_active)
);
// ----------------------------------------------------------------
// helpers
// ----------------------------------------------------------------
task automatic test_done();
    if (failures == 0 && checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
endtask
task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
        failures++;
        $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
endtask
task automatic apb(input logic wr, input logic [11:0] a,
                   input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
endtask
// 0 wait, 1 stop, 2 interrupt, 3 external interrupt, 4 trip, 5 reset
task automatic pulse(input int k);
    @(posedge clk);
    case (k)
        0: wait_req  <= 1'b1;
        1: stop_req  <= 1'b1;
        2: int_req   <= 1'b1;
        3: ext_int   <= 1'b1;
        4: lowv_trip <= 1'b1;
        default: reset_req <= 1'b1;
    endcase
    @(posedge clk);
    {wait_req, stop_req, int_req, ext_int, lowv_trip, reset_req} <= '0;
    #1;
endtask
task automatic wait_clk();
    n = 0;
    while (cpu_clk_en !== 1'b1 && n < 200) begin
        @(posedge clk);
        #1;
        n++;
    end
endtask
// ----------------------------------------------------------------
// clock and timeout
// ----------------------------------------------------------------
initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
end
always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
        failures++;
        test_done();
    end
end
// ----------------------------------------------------------------
// main sequence
// ----------------------------------------------------------------
initial begin
    failures = 0; checked = 0; cycles = 0;
    reset_n = 1'b0; ce = 1'b1; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = '0; pwdata = '0;
    {wait_req, stop_req, int_req, ext_int, lowv_trip, reset_req} = '0;
    rows[0] = '{8'h00, 1'b1, 1'b0, 1'b1};
    rows[1] = '{8'h10, 1'b0, 1'b0, 1'b1};
    rows[2] = '{8'h08, 1'b1, 1'b1, 1'b1};
    rows[3] = '{8'h01, 1'b1, 1'b0, 1'b0};
    rows[4] = '{8'h3F, 1'b0, 1'b1, 1'b0};
    repeat (6) @(posedge clk);
    chk(cpu_clk_en, 1'b0);
    chk(lowv_power_en, 1'b1);
    reset_n <= 1'b1;
    #1;
    wait_clk();
    chk(n, POR_N);
    apb(1'b0, `STAT_OFF, '0);
    chk(rd[4:0], 5'b00010);
    apb(1'b0, 12'h010, '0);
    chk({err, rd}, {1'b1, 32'h0});
    apb(1'b1, `WDCLR_OFF, 32'h0000_00FF);
    apb(1'b0, `WDCLR_OFF, '0);
    chk(rd, 32'h0);
    foreach (rows[i]) begin
        apb(1'b1, `CFG_OFF, {24'h0, rows[i].cfg});
        apb(1'b0, `CFG_OFF, '0);
        chk(rd, {24'h0, rows[i].cfg});
        chk(lowv_power_en, rows[i].pwr);
        chk(lowv_range_5v, rows[i].rng);
        chk(watchdog_active, rows[i].wd);
    end
    apb(1'b1, `CFG_OFF, 32'h0);
    pulse(0);
    chk({imask_clear, cpu_clk_en}, 2'b10);
    repeat (3) @(posedge clk);
    #1;
    chk(cpu_clk_en, 1'b0);
    pulse(2);
    chk({cpu_clk_en, imask_set}, 2'b10);
    @(posedge clk);
    ce <= 1'b0;
    pulse(0);
    chk({pready, imask_clear, cpu_clk_en}, 3'b001);
    @(posedge clk);
    ce <= 1'b1;
    pulse(0);
    pulse(5);
    chk({sys_reset, imask_set, imask_clear, cpu_clk_en}, 4'b1101);
    pulse(1);
    chk({sys_reset, imask_set, cpu_clk_en}, 3'b111);
    apb(1'b0, `STAT_OFF, '0);
    chk({rd[7], rd[4:0]}, 6'b1_00010);
    for (int s = 0; s < 2; s++) begin
        apb(1'b1, `CFG_OFF, s == 0 ? 32'h06 : 32'h02);
        pulse(1);
        chk({imask_clear, cpu_clk_en}, 2'b10);
        pulse(3);
        chk(cpu_clk_en, 1'b0);
        wait_clk();
        chk(n, s == 0 ? SHORT_N : LONG_N);
        chk(imask_set, 1'b0);
    end
    apb(1'b1, `CFG_OFF, 32'h06);
    pulse(1);
    pulse(4);
    chk({sys_reset, imask_set}, 2'b11);
    wait_clk();
    chk(n, LONG_N);
    apb(1'b1, `CFG_OFF, 32'h20);
    pulse(4);
    chk(sys_reset, 1'b0);
    apb(1'b1, `CFG_OFF, 32'h10);
    pulse(4);
    chk(sys_reset, 1'b0);
    apb(1'b1, `CFG_OFF, 32'h00);
    pulse(4);
    chk(sys_reset, 1'b1);
    apb(1'b1, `CFG_OFF, 32'h0B);
    pulse(5);
    chk(sys_reset, 1'b1);
    apb(1'b0, `CFG_OFF, '0);
    chk(rd, 32'h08);
    @(posedge clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    #1;
    wait_clk();
    chk(n, POR_N);
    apb(1'b0, `CFG_OFF, '0);
    chk(rd, 32'h00);
    test_done();
end
endmodule // tb_top

// *** watchdog_counter.sv ***
// watchdog counter that counts while RUN_EN is high, with clear and overflow pulse
`timescale 1ns/1ps
module watchdog_counter (
    input  wire logic CLK,
    input  wire logic RESET_N,
    input  wire logic CE,
    input  wire logic RUN_EN,
    input  wire logic CLEAR,
    output logic      OVERFLOW
);

    cfg_lp_pkg::wdog_s r_reg;
    cfg_lp_pkg::wdog_s r_next;

    // ------------------------------------------------------------
    // counter
    // ------------------------------------------------------------
    always_comb begin
        r_next     = r_reg;
        r_next.ovf = 1'b0;
        if (CLEAR) begin
            r_next.cnt = '0;
        end else if (RUN_EN) begin
            r_next.cnt = r_reg.cnt + 1'b1;
            r_next.ovf = &r_reg.cnt;
        end
    end

    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            r_reg <= '0;
        end else if (CE) begin
            r_reg <= r_next;
        end
    end

    assign OVERFLOW = r_reg.ovf;

endmodule // watchdog_counter
